// >>> hw/dsc_pkg.sv
// Purpose: Constants for the dual output split control block
// Assumes: Percent values in tenths of a percent, 0..1000
// Notes: Gain ratio in hundredths, 100 means 1.00
package dsc_pkg;
	localparam int PW = 11;
	localparam int SW = 13;
	localparam int GW = 9;
	localparam int PVW = 16;
	localparam logic signed [SW-1:0] PCT_ZERO = 13'sh0000;
	localparam logic signed [SW-1:0] PCT_HALF = 13'sh01f4;
	localparam logic signed [SW-1:0] PCT_FULL = 13'sh03e8;
	localparam logic [GW-1:0] GAIN_UNITY = 9'h064;
	localparam logic [GW-1:0] GAIN_RESET = 9'h064;
	localparam logic [PW-1:0] BIAS_RESET = 11'h1f4;
	localparam logic [PW-1:0] HI_RESET = 11'h3e8;
	localparam logic [PW-1:0] LO_RESET = 11'h000;
	localparam logic [3:0] A_MODE = 4'h0;
	localparam logic [3:0] A_ACT = 4'h1;
	localparam logic [3:0] A_POFS1 = 4'h2;
	localparam logic [3:0] A_POFS2 = 4'h3;
	localparam logic [3:0] A_SOFS1 = 4'h4;
	localparam logic [3:0] A_SOFS2 = 4'h5;
	localparam logic [3:0] A_BIAS = 4'h6;
	localparam logic [3:0] A_GAIN = 4'h7;
	localparam logic [3:0] A_LIMLO = 4'h8;
	localparam logic [3:0] A_LIMHI = 4'h9;
	localparam logic [3:0] A_DBAND = 4'ha;
	localparam logic [3:0] A_OUT1 = 4'hb;
	localparam logic [3:0] A_OUT2 = 4'hc;
	localparam logic [3:0] A_LIMOUT = 4'hd;
	localparam int F_SPLIT = 0;
	localparam int F_ALG0 = 1;
	localparam int F_ALG1 = 2;
	localparam int F_ACT1 = 0;
	localparam int F_ACT2 = 1;
	typedef enum logic [1:0] {
		DSC_ALG_PROP = 2'b00,
		DSC_ALG_MIXED = 2'b01,
		DSC_ALG_ONOFF = 2'b10
	} dsc_alg_e;
endpackage

// >>> hw/dsc_onoff.sv
// Purpose: One on/off output with deadband hysteresis
// Assumes: Error is process variable minus switch point, signed
// Notes: Reverse action turns on below the point, direct above
`timescale 1ns/10ps
`default_nettype none
module dsc_onoff
	import dsc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic direct,
	input wire logic signed [PVW:0] err,
	input wire logic [PVW-1:0] deadband,
	output logic on
);
	typedef struct packed {
		logic on;
	} dsc_sw_s;
	dsc_sw_s st, next_st;
	logic signed [PVW+1:0] act_err;
	logic signed [PVW+1:0] half;
	always_comb begin
		next_st = st;
		act_err = direct ? {err[PVW], err} : -{err[PVW], err};
		half = $signed({3'h0, deadband[PVW-1:1]});
		// Hold inside the band so the relay does not chatter
		if (!enable) begin
			next_st.on = 1'b0;
		end else if (act_err > half) begin
			next_st.on = 1'b1;
		end else if (act_err < -half) begin
			next_st.on = 1'b0;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign on = st.on;
endmodule
`default_nettype wire

// >>> hw/dsc_top.sv
// Purpose: Split one loop's control output into two physical outputs
// Assumes: Loop error arrives as signed tenths of percent; pv and sp as raw units
// Notes: Register port, read data one cycle after the read strobe
// Operation
// - Split mode drives two outputs from one loop instead of one.
// - Mixed algorithm: first output proportional, second output on/off.
// - Each output independently direct or reverse acting.
// - Per-output offsets: percent for proportional, process units for on/off.
// - Offsets give a dead zone or an overlap band around setpoint.
// - Load-line bias sets output at zero error; stays with integral.
// - Gain ratio scales only the second output.
// - Gain 2.0 full at 25%, 1.0 at 0%, 0.5 peaks 50%.
// - Low and high limits clamp the combined output before splitting.
// - On/off second output ignores the gain ratio.
// - On/off second output uses single-output deadband hysteresis.
// - Both on/off: switch on process variable versus setpoint plus offset.
// - Positive percent offset moves activation below 50%, negative above.
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module dsc_top
	import dsc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic signed [SW-1:0] loop_term,
	input wire logic [PVW-1:0] pv,
	input wire logic [PVW-1:0] sp,
	output logic [PW-1:0] out1,
	output logic [PW-1:0] out2,
	output logic out1_on,
	output logic out2_on,
	output logic split_active
);
	typedef struct packed {
		logic [2:0] first_loop_output_mode;
		logic act1;
		logic act2;
		logic signed [SW-1:0] first_output_percent_offset;
		logic signed [SW-1:0] second_output_percent_offset;
		logic signed [PVW-1:0] first_output_switch_offset;
		logic signed [PVW-1:0] second_output_switch_offset;
		logic [PW-1:0] load_line_bias;
		logic [GW-1:0] second_output_gain_ratio;
		logic [PW-1:0] lim_lo;
		logic [PW-1:0] lim_hi;
		logic [PVW-1:0] deadband;
		logic [PW-1:0] lim_out;
		logic [PW-1:0] out1;
		logic [PW-1:0] out2;
		logic out1_on;
		logic out2_on;
		logic split_active;
		logic [15:0] rdata;
	} dsc_top_s;
	dsc_top_s st, next_st;
	logic rst_meta, rst_sync;
	logic sw1_on, sw2_on;
	logic signed [PVW:0] err1, err2;
	dsc_alg_e alg;
	logic signed [SW+1:0] raw;
	logic signed [SW+1:0] lim;
	logic signed [SW+1:0] d1, d2;
	logic signed [SW+GW+1:0] g2;
	logic onoff1, onoff2;
	function automatic logic [PW-1:0] clamp_pct(input logic signed [SW+GW+1:0] v);
		logic [PW-1:0] r;
		r = PW'(PCT_ZERO);
		if (v > $signed({{(GW+2){1'b0}}, PCT_FULL})) begin
			r = PW'(PCT_FULL);
		end else if (v > 0) begin
			r = v[PW-1:0];
		end
		return r;
	endfunction
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end
	always_comb begin
		alg = dsc_alg_e'(st.first_loop_output_mode[F_ALG1:F_ALG0]);
		onoff1 = st.first_loop_output_mode[F_SPLIT] && alg == DSC_ALG_ONOFF;
		onoff2 = st.first_loop_output_mode[F_SPLIT] && alg != DSC_ALG_PROP;
		// Switch point is setpoint plus that output's own offset
		err1 = $signed({1'b0, pv}) - $signed({1'b0, sp})
			- {st.first_output_switch_offset[PVW-1], st.first_output_switch_offset};
		err2 = $signed({1'b0, pv}) - $signed({1'b0, sp})
			- {st.second_output_switch_offset[PVW-1], st.second_output_switch_offset};
	end
	dsc_onoff u_sw1 (
		.ref_clk(ref_clk),
		.rst_n(rst_sync),
		.enable(onoff1),
		.direct(st.act1),
		.err(err1),
		.deadband(st.deadband),
		.on(sw1_on)
	);
	dsc_onoff u_sw2 (
		.ref_clk(ref_clk),
		.rst_n(rst_sync),
		.enable(onoff2),
		.direct(st.act2),
		.err(err2),
		.deadband(st.deadband),
		.on(sw2_on)
	);
	always_comb begin
		next_st = st;
		// Bias added after integral too, so zero error sits at the bias
		raw = {{2{loop_term[SW-1]}}, loop_term} + $signed({4'h0, st.load_line_bias});
		lim = raw;
		// Clamp before splitting so both outputs see the same limited value
		if (lim > $signed({4'h0, st.lim_hi})) begin
			lim = $signed({4'h0, st.lim_hi});
		end
		if (lim < $signed({4'h0, st.lim_lo})) begin
			lim = $signed({4'h0, st.lim_lo});
		end
		// Offset shifts the 50% pivot; positive moves it left
		d1 = lim - {{2{PCT_HALF[SW-1]}}, PCT_HALF}
			+ {{2{st.first_output_percent_offset[SW-1]}}, st.first_output_percent_offset};
		d2 = lim - {{2{PCT_HALF[SW-1]}}, PCT_HALF}
			+ {{2{st.second_output_percent_offset[SW-1]}}, st.second_output_percent_offset};
		// Direct output falls with control output; twice the span covers 0..100
		if (st.act1) begin
			d1 = -d1;
		end
		if (st.act2) begin
			d2 = -d2;
		end
		// Gain applies to the second output only; first stays plain
		g2 = (SW+GW+2)'(d2 * $signed({1'b0, st.second_output_gain_ratio}) * 2
			/ $signed({1'b0, GAIN_UNITY}));
		next_st.lim_out = lim[PW-1:0];
		next_st.split_active = st.first_loop_output_mode[F_SPLIT];
		if (st.first_loop_output_mode[F_SPLIT]) begin
			// Dead zone or overlap falls out of the two pivots
			next_st.out1 = onoff1 ? (sw1_on ? PW'(PCT_FULL) : PW'(PCT_ZERO))
				: clamp_pct((SW+GW+2)'(d1 * 2));
			next_st.out2 = onoff2 ? (sw2_on ? PW'(PCT_FULL) : PW'(PCT_ZERO))
				: clamp_pct(g2);
			next_st.out1_on = onoff1 ? sw1_on : clamp_pct((SW+GW+2)'(d1 * 2)) != '0;
			next_st.out2_on = onoff2 ? sw2_on : clamp_pct(g2) != '0;
		end else begin
			// Single output: loop drives output one only
			next_st.out1 = lim[PW-1:0];
			next_st.out2 = PW'(PCT_ZERO);
			next_st.out1_on = lim != 0;
			next_st.out2_on = 1'b0;
		end
		next_st.rdata = 16'h0000;
		if (wr) begin
			unique case (addr)
				A_MODE: next_st.first_loop_output_mode = wdata[2:0];
				A_ACT: begin
					next_st.act1 = wdata[F_ACT1];
					next_st.act2 = wdata[F_ACT2];
				end
				A_POFS1: next_st.first_output_percent_offset = wdata[SW-1:0];
				A_POFS2: next_st.second_output_percent_offset = wdata[SW-1:0];
				A_SOFS1: next_st.first_output_switch_offset = wdata;
				A_SOFS2: next_st.second_output_switch_offset = wdata;
				A_BIAS: next_st.load_line_bias = wdata[PW-1:0];
				A_GAIN: next_st.second_output_gain_ratio = wdata[GW-1:0];
				A_LIMLO: next_st.lim_lo = wdata[PW-1:0];
				A_LIMHI: next_st.lim_hi = wdata[PW-1:0];
				A_DBAND: next_st.deadband = wdata;
				default: ;
			endcase
		end
		if (rd) begin
			unique case (addr)
				A_MODE: next_st.rdata = {13'h0000, st.first_loop_output_mode};
				A_ACT: next_st.rdata = {14'h0000, st.act2, st.act1};
				A_POFS1: next_st.rdata = 16'(st.first_output_percent_offset);
				A_POFS2: next_st.rdata = 16'(st.second_output_percent_offset);
				A_SOFS1: next_st.rdata = st.first_output_switch_offset;
				A_SOFS2: next_st.rdata = st.second_output_switch_offset;
				A_BIAS: next_st.rdata = {5'h00, st.load_line_bias};
				A_GAIN: next_st.rdata = {7'h00, st.second_output_gain_ratio};
				A_LIMLO: next_st.rdata = {5'h00, st.lim_lo};
				A_LIMHI: next_st.rdata = {5'h00, st.lim_hi};
				A_DBAND: next_st.rdata = st.deadband;
				A_OUT1: next_st.rdata = {5'h00, st.out1};
				A_OUT2: next_st.rdata = {5'h00, st.out2};
				A_LIMOUT: next_st.rdata = {5'h00, st.lim_out};
				default: next_st.rdata = 16'h0000;
			endcase
		end
	end
	always_ff @(posedge ref_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			st <= '0;
			st.load_line_bias <= BIAS_RESET;
			st.second_output_gain_ratio <= GAIN_RESET;
			st.lim_lo <= LO_RESET;
			st.lim_hi <= HI_RESET;
		end else begin
			st <= next_st;
		end
	end
	assign rdata = st.rdata;
	assign out1 = st.out1;
	assign out2 = st.out2;
	assign out1_on = st.out1_on;
	assign out2_on = st.out2_on;
	assign split_active = st.split_active;
endmodule
`default_nettype wire

// >>> test/dsc_chk.sv
// Purpose: Port checks for dsc_top
// Assumes: Outputs and read data are registered
// Notes: Sees only top ports
`timescale 1ns/10ps
`default_nettype none
module dsc_chk
	import dsc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [3:0] addr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic [PW-1:0] out1,
	input wire logic [PW-1:0] out2,
	input wire logic out1_on,
	input wire logic out2_on,
	input wire logic split_active
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	a_out1_range: assert property (out1 <= 11'h3e8) else $error("out1 over full");
	a_out2_range: assert property (out2 <= 11'h3e8) else $error("out2 over full");
	a_single_out2: assert property (!split_active |-> out2 == 11'h000 && !out2_on)
		else $error("out2 live unsplit");
	a_single_flag: assert property (!split_active |-> out1_on == (out1 != 11'h000))
		else $error("out1 flag wrong");
	a_read_out1: assert property (rd && addr == A_OUT1 |=> rdata == {5'h00, $past(out1)})
		else $error("out1 readback");
	a_read_out2: assert property (rd && addr == A_OUT2 |=> rdata == {5'h00, $past(out2)})
		else $error("out2 readback");
	a_read_gap: assert property (rd && addr > A_LIMOUT |=> rdata == 16'h0000)
		else $error("unmapped read");
	a_read_idle: assert property (!rd |=> rdata == 16'h0000) else $error("rdata not idle");
endmodule
bind dsc_top dsc_chk i_dsc_chk (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .rd(rd),
	.rdata(rdata), .out1(out1), .out2(out2), .out1_on(out1_on), .out2_on(out2_on),
	.split_active(split_active));
`default_nettype wire

// >>> test/dsc_loop_src.sv
// Purpose: Loop calculation side feeding dsc_top
// Assumes: One loop update per clock at most
// Notes: Values change only after an edge
`timescale 1ns/10ps
`default_nettype none
module dsc_loop_src
	import dsc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic signed [SW-1:0] next_term,
	input wire logic [PVW-1:0] next_pv,
	input wire logic [PVW-1:0] next_sp,
	output logic signed [SW-1:0] loop_term = 13'sh0000,
	output logic [PVW-1:0] pv = 16'h0000,
	output logic [PVW-1:0] sp = 16'h0000
);
	always @(posedge ref_clk) begin
		loop_term <= next_term;
		pv <= next_pv;
		sp <= next_sp;
	end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Purpose: Self-checking bench for dsc_top
// Assumes: Reversed output rises with control output, direct one falls
// Notes: Deadband fixed at 20 units
`timescale 1ns/10ps
`default_nettype none
module testbench
	import dsc_pkg::*;
;
	logic ref_clk = 0, rst_n = 0, wr = 0, rd = 0, out1_on, out2_on, split_active;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000, rdata, v;
	logic signed [SW-1:0] next_term = 13'sh0000, loop_term;
	logic [PVW-1:0] next_pv = 16'h0000, next_sp = 16'h0000, pv, sp;
	logic [PW-1:0] out1, out2;
	logic [31:0] seed = 32'h5000;
	int n_errors = 0, comparisons = 0, cycles = 0;
	int lo = 0, hi = 1000, lim, o1, o2, p1, p2, s1 = 0, s2 = 0;
	int gains [3] = '{200, 100, 50};
	int dflt [16] = '{0, 0, 0, 0, 0, 0, 500, 100, 0, 1000, 0, 500, 0, 500, 0, 0};
	dsc_loop_src i_dsc_loop_src (.ref_clk(ref_clk), .next_term(next_term), .next_pv(next_pv),
		.next_sp(next_sp), .loop_term(loop_term), .pv(pv), .sp(sp));
	dsc_top i_dsc_top (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .loop_term(loop_term), .pv(pv), .sp(sp), .out1(out1),
		.out2(out2), .out1_on(out1_on), .out2_on(out2_on), .split_active(split_active));
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic conclude();
		$display("n_errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles > 5000) begin
			n_errors++;
			conclude();
		end
	end
	task automatic chk(input logic [15:0] seen, input int exp);
		comparisons++;
		if (seen !== 16'(exp)) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, 16'(exp));
		end
	endtask
	task automatic bus(input logic w, input logic r, input logic [3:0] a, input int d);
		@(posedge ref_clk);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= 16'(d);
	endtask
	task automatic rreg(input logic [3:0] a);
		bus(1'b0, 1'b1, a, 0);
		bus(1'b0, 1'b0, 4'h0, 0);
		#1 v = rdata;
	endtask
	function automatic int rnd(input int n);
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return int'(seed % n);
	endfunction
	function automatic int clip(input int x, input int l, input int h);
		return x < l ? l : (x > h ? h : x);
	endfunction
	// Direct falls with control output, reversed rises
	function automatic int prop(input int l, input int dir, input int ofs, input int gn);
		return clip((dir ? 500 - l - ofs : l - 500 + ofs) * 2 * gn / 100, 0, 1000);
	endfunction
	function automatic int hyst(input int s, input int dir, input int err);
		if (dir ? err > 10 : err < -10) return 1;
		if (dir ? err < -10 : err > 10) return 0;
		return s;
	endfunction
	// Relays lag one extra cycle, so four edges cover every path
	task automatic drive(input int t);
		bus(1'b0, 1'b0, 4'h0, 0);
		next_term <= 13'(t);
		lim = clip(t + 500, lo, hi);
		repeat (4) @(posedge ref_clk);
		#1;
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (int a = 0; a < 16; a++) begin
			rreg(4'(a));
			chk(v, dflt[a]);
		end
		bus(1'b1, 1'b0, A_LIMLO, 200);
		bus(1'b1, 1'b0, A_LIMHI, 800);
		lo = 200;
		hi = 800;
		for (int k = 0; k < 8; k++) begin
			drive(rnd(1400) - 700);
			chk(out1, lim);
			chk(out2, 0);
			chk(out1_on, lim != 0);
			chk(split_active, 0);
		end
		bus(1'b1, 1'b0, A_MODE, 1);
		for (int act = 0; act < 4; act++) begin
			for (int gi = 0; gi < 3; gi++) begin
				o1 = rnd(201) - 100;
				o2 = rnd(201) - 100;
				lo = rnd(200);
				hi = 800 + rnd(201);
				bus(1'b1, 1'b0, A_ACT, act);
				bus(1'b1, 1'b0, A_GAIN, gains[gi]);
				bus(1'b1, 1'b0, A_POFS1, o1);
				bus(1'b1, 1'b0, A_POFS2, o2);
				bus(1'b1, 1'b0, A_LIMLO, lo);
				bus(1'b1, 1'b0, A_LIMHI, hi);
				for (int k = 0; k < 4; k++) begin
					drive(k == 0 ? 0 : rnd(1400) - 700);
					p1 = prop(lim, act & 1, o1, 100);
					p2 = prop(lim, act >> 1, o2, gains[gi]);
					chk(out1, p1);
					chk(out2, p2);
					chk(out1_on, p1 != 0);
					chk(out2_on, p2 != 0);
					chk(split_active, 1);
					rreg(A_LIMOUT);
					chk(v, lim);
				end
			end
		end
		bus(1'b1, 1'b0, A_POFS1, 0);
		bus(1'b1, 1'b0, A_SOFS1, -10);
		bus(1'b1, 1'b0, A_SOFS2, 10);
		bus(1'b1, 1'b0, A_DBAND, 20);
		bus(1'b1, 1'b0, A_ACT, 2);
		bus(1'b1, 1'b0, A_GAIN, 50);
		next_sp <= 16'h03e8;
		for (int m = 3; m < 6; m += 2) begin
			bus(1'b1, 1'b0, 4'h0, m);
			for (int k = 0; k < 30; k++) begin
				o1 = k == 0 ? 0 : 960 + rnd(81);
				next_pv <= 16'(o1);
				drive(rnd(1400) - 700);
				s1 = hyst(s1, 0, o1 - 990);
				s2 = hyst(s2, 1, o1 - 1010);
				chk(out2_on, s2);
				chk(out2, s2 ? 1000 : 0);
				if (m == 5) begin
					chk(out1_on, s1);
					chk(out1, s1 ? 1000 : 0);
				end else begin
					chk(out1, prop(lim, 0, 0, 100));
				end
			end
		end
		conclude();
	end
endmodule
`default_nettype wire
